// ===== core/rsc_pkg.sv
// Purpose: shared constants and types of the reclose shot counter
// Assumes: 10 MHz reference clock, 60 Hz power system
// Notes: timer settings count whole power-system cycles
package rsc_pkg;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int SHOT_W = 3;
    localparam int TMR_W = 16;
    localparam int N_OI = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int LINE_CYCLE_NS = 16666667;
    localparam int CLKS_PER_CYCLE = LINE_CYCLE_NS / CLK_PERIOD_NS;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_RST_IVL = 8'h04;
    localparam logic [7:0] ADR_OI_BASE = 8'h08;
    localparam logic [7:0] ADR_STATE = 8'h18;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h20;
    // ctrl fields: [4:0] shot mask, leftmost (bit 4) is shot zero
    localparam int CTRL_MASK_LSB = 0;
    localparam int CTRL_SEQ_EN = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [TMR_W-1:0] RST_IVL_RST = 16'h0708;
    localparam logic [TMR_W-1:0] OI_RST = 16'h0000;
    // irq / status bits
    localparam int IRQ_W = 4;
    localparam int EV_RESET = 0;
    localparam int EV_LOCKOUT = 1;
    localparam int EV_CLOSE = 2;
    localparam int EV_SHOT = 3;
    // state word fields
    localparam int ST_RS = 3;
    localparam int ST_CY = 4;
    localparam int ST_LO = 5;
    localparam int ST_SH = 6;
    // ----------------------------------------
    // recloser states, gray along reset-open-close-closed
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        RSC_RESET = 3'h0,
        RSC_OPEN = 3'h1,
        RSC_CLOSING = 3'h3,
        RSC_CLOSED = 3'h2,
        RSC_LOCKOUT = 3'h6
    } rsc_state_t;
endpackage : rsc_pkg

// ===== core/rsc_tmr_if.sv
// Purpose: control bundle between the sequencer and a cycle timer
// Assumes: single clock domain
// Notes: expired is a one-cycle pulse
`timescale 1ns/10ps
interface rsc_tmr_if;
    logic restart;
    logic run;
    logic [rsc_pkg::TMR_W-1:0] limit;
    logic expired;
    modport ctl (output restart, output run, output limit, input expired);
    modport tmr (input restart, input run, input limit, output expired);
endinterface : rsc_tmr_if

// ===== core/rsc_cyc_timer.sv
// Purpose: power-system cycle interval timer
// Assumes: tick_i is one clock wide, once per power-system cycle
// Notes: a zero limit never expires; expiry fires once until restart
`timescale 1ns/10ps
module rsc_cyc_timer
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // time base
    input wire logic tick_i,
    // control
    rsc_tmr_if.tmr t
);
    import rsc_pkg::*;

    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;
    logic exp_r;
    logic exp_nxt;

    // count ticks while running, stop at the limit
    always_comb
    begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        exp_nxt = 1'b0;
        if (t.restart)
        begin
            cnt_nxt = '0;
            done_nxt = 1'b0;
        end
        else if (t.run && tick_i && !done_r && t.limit != '0)
        begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_nxt == t.limit)
            begin
                done_nxt = 1'b1;
                exp_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= '0;
            done_r <= 1'b0;
            exp_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign t.expired = exp_r;
endmodule : rsc_cyc_timer

// ===== core/rsc_top.sv
// Purpose: multiple-shot reclose sequencer with shot counter
// Assumes: breaker pins are asynchronous; registers on a plain strobe port
// Notes: open-interval, close-failure and trip-failure detail left out
// Function
// - shots allowed equal the number of nonzero open interval settings
// - open interval expiry increments the shot count and asserts close in the same cycle
// - in reset after a reset interval the count is zero, reset bit set
// - shot bit is high when the count is selected in the shot mask
// - mask leftmost position selects shot zero, rightmost shot four
// - breaker closed a full reset interval in cycle: enter reset, count zero
// - trip before reset interval ends moves to the next shot, cycle held
// - trip after last shot: lockout, cycle off, count and shot bit held
// - coordination pickup then dropout, breaker closed, no trip: count up
// - coordination step restarts reset timer, reset state stays
// - reset timer expiry after coordination steps clears the count
// - coordination never counts past the last permitted shot
// - first trip from reset drops reset bit and raises cycle bit
// - reset timer starts at breaker closed after close; lockout held till expiry
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module rsc_top
#(
    parameter int CYC_CLKS = rsc_pkg::CLKS_PER_CYCLE
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // breaker and protection pins
    input wire logic breaker_closed_input_i,
    input wire logic programmable_trip_condition_i,
    input wire logic seq_coord_condition_i,
    input wire logic direct_close_input_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // breaker commands
    output logic close_o,
    output logic trip_o,
    // state indications
    output logic reset_state_bit_o,
    output logic reclose_cycle_bit_o,
    output logic lockout_state_bit_o,
    output logic shot_indication_bit_o,
    output logic [rsc_pkg::SHOT_W-1:0] shot_o,
    output logic irq_o
);
    import rsc_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // shot mask lookup; position 4 of the mask is shot zero
    function automatic logic shot_hit(input logic [4:0] m, input logic [SHOT_W-1:0] s);
        shot_hit = (s <= 3'h4) ? m[3'h4 - s] : 1'b0;
    endfunction : shot_hit

    // count of nonzero open intervals
    function automatic logic [SHOT_W-1:0] n_shots(input logic [N_OI*TMR_W-1:0] oi);
        n_shots = '0;
        for (int k = 0; k < N_OI; k++)
        begin
            if (oi[k*TMR_W +: TMR_W] != '0)
            begin
                n_shots = n_shots + 1'b1;
            end
        end
    endfunction : n_shots

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int NPIN = 4;
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] pin_s;
    assign pin_in = {direct_close_input_i, seq_coord_condition_i,
                     programmable_trip_condition_i, breaker_closed_input_i};

    // a change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_sync
            logic [2:0] sh_r;
            logic st_r;
            always_ff @(posedge ref_clk_i)
            begin
                if (!rstn_i)
                begin
                    sh_r <= 3'h0;
                    st_r <= 1'b0;
                end
                else
                begin
                    sh_r <= {sh_r[1:0], pin_in[g]};
                    st_r <= (sh_r[1] == sh_r[2]) ? sh_r[2] : st_r;
                end
            end
            assign pin_s[g] = st_r;
        end
    endgenerate

    logic bk_closed;
    logic trip_c;
    logic seq_c;
    logic dc_c;
    assign bk_closed = pin_s[0];
    assign trip_c = pin_s[1];
    assign seq_c = pin_s[2];
    assign dc_c = pin_s[3];

    // ----------------------------------------
    // power-system cycle tick
    // ----------------------------------------
    logic [17:0] div_r;
    logic [17:0] div_nxt;
    logic tick_r;
    logic tick_nxt;

    // all interval timers share this time base
    always_comb
    begin
        tick_nxt = (div_r == 18'(CYC_CLKS - 1));
        div_nxt = tick_nxt ? 18'h00000 : div_r + 18'h00001;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            div_r <= 18'h00000;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0] ctrl_r;
    logic [5:0] ctrl_nxt;
    logic [TMR_W-1:0] rst_ivl_r;
    logic [TMR_W-1:0] rst_ivl_nxt;
    logic [N_OI*TMR_W-1:0] oi_r;
    logic [N_OI*TMR_W-1:0] oi_nxt;
    logic [IRQ_W-1:0] ist_r;
    logic [IRQ_W-1:0] ist_nxt;
    logic [IRQ_W-1:0] imask_r;
    logic [IRQ_W-1:0] imask_nxt;
    logic [IRQ_W-1:0] ev;
    logic [31:0] rd_nxt;
    logic irq_nxt;
    logic [SHOT_W-1:0] nsh;
    assign nsh = n_shots(oi_r);

    // writes, w1c status, registered read data
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        rst_ivl_nxt = rst_ivl_r;
        oi_nxt = oi_r;
        imask_nxt = imask_r;
        ist_nxt = ist_r;
        rd_nxt = 32'h00000000;
        if (wr_i)
        begin
            if (addr_i == ADR_CTRL)
                ctrl_nxt = wdata_i[5:0];
            if (addr_i == ADR_RST_IVL)
                rst_ivl_nxt = wdata_i[TMR_W-1:0];
            for (int k = 0; k < N_OI; k++)
            begin
                if (addr_i == ADR_OI_BASE + 8'(4 * k))
                    oi_nxt[k*TMR_W +: TMR_W] = wdata_i[TMR_W-1:0];
            end
            if (addr_i == ADR_IRQ_MASK)
                imask_nxt = wdata_i[IRQ_W-1:0];
            if (addr_i == ADR_IRQ_STAT)
                ist_nxt = ist_r & ~wdata_i[IRQ_W-1:0];
        end
        // a new event beats a clear in the same cycle
        ist_nxt = ist_nxt | ev;
        irq_nxt = |(ist_nxt & imask_nxt);
        if (rd_i)
        begin
            if (addr_i == ADR_CTRL)
                rd_nxt = {26'h0000000, ctrl_r};
            if (addr_i == ADR_RST_IVL)
                rd_nxt = {16'h0000, rst_ivl_r};
            for (int k = 0; k < N_OI; k++)
            begin
                if (addr_i == ADR_OI_BASE + 8'(4 * k))
                    rd_nxt = {16'h0000, oi_r[k*TMR_W +: TMR_W]};
            end
            if (addr_i == ADR_STATE)
                rd_nxt = {25'h0000000, shot_indication_bit_o, lockout_state_bit_o,
                          reclose_cycle_bit_o, reset_state_bit_o, shot_o};
            if (addr_i == ADR_IRQ_STAT)
                rd_nxt = {28'h0000000, ist_r};
            if (addr_i == ADR_IRQ_MASK)
                rd_nxt = {28'h0000000, imask_r};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl_r <= CTRL_RST;
            rst_ivl_r <= RST_IVL_RST;
            oi_r <= {N_OI{OI_RST}};
            ist_r <= '0;
            imask_r <= '0;
            rdata_o <= 32'h00000000;
            irq_o <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            rst_ivl_r <= rst_ivl_nxt;
            oi_r <= oi_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            rdata_o <= rd_nxt;
            irq_o <= irq_nxt;
        end
    end

    // ----------------------------------------
    // interval timers
    // ----------------------------------------
    rsc_tmr_if rst_t ();
    rsc_tmr_if oi_t ();

    rsc_cyc_timer u_rst_tmr
    (
        .ref_clk_i (ref_clk_i),
        .rstn_i (rstn_i),
        .tick_i (tick_r),
        .t (rst_t)
    );

    rsc_cyc_timer u_oi_tmr
    (
        .ref_clk_i (ref_clk_i),
        .rstn_i (rstn_i),
        .tick_i (tick_r),
        .t (oi_t)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    rsc_state_t st_r;
    rsc_state_t st_nxt;
    logic [SHOT_W-1:0] shot_nxt;
    logic close_nxt;
    logic bk_q_r;
    logic seq_pk_r;
    logic seq_pk_nxt;
    logic seq_step;
    logic bk_rise;
    logic last_shot;

    assign bk_rise = bk_closed && !bk_q_r;
    assign last_shot = (shot_o >= nsh);
    // dropout after a pickup, breaker closed, no trip
    assign seq_step = ctrl_r[CTRL_SEQ_EN] && seq_pk_r && !seq_c && bk_closed && !trip_c;

    always_comb
    begin
        st_nxt = st_r;
        shot_nxt = shot_o;
        close_nxt = close_o;
        ev = '0;
        seq_pk_nxt = seq_pk_r;
        rst_t.restart = 1'b0;
        rst_t.run = bk_closed;
        rst_t.limit = rst_ivl_r;
        oi_t.restart = 1'b0;
        oi_t.run = !bk_closed && !trip_c;
        oi_t.limit = oi_r[shot_o[1:0]*TMR_W +: TMR_W];
        // coordination pickup only counts with breaker closed
        if (seq_c && bk_closed && !trip_c)
            seq_pk_nxt = 1'b1;
        else if (seq_step || !bk_closed || trip_c)
            seq_pk_nxt = 1'b0;
        unique case (st_r)
            RSC_RESET:
            begin
                if (trip_c)
                begin
                    oi_t.restart = 1'b1;
                    st_nxt = last_shot ? RSC_LOCKOUT : RSC_OPEN;
                    ev[EV_LOCKOUT] = last_shot;
                end
                else if (seq_step)
                begin
                    rst_t.restart = 1'b1;
                    if (!last_shot)
                    begin
                        shot_nxt = shot_o + 1'b1;
                        ev[EV_SHOT] = 1'b1;
                    end
                end
                else if (rst_t.expired)
                    shot_nxt = '0;
            end
            RSC_OPEN:
            begin
                if (oi_t.expired)
                begin
                    shot_nxt = shot_o + 1'b1;
                    close_nxt = 1'b1;
                    ev[EV_SHOT] = 1'b1;
                    ev[EV_CLOSE] = 1'b1;
                    st_nxt = RSC_CLOSING;
                end
            end
            RSC_CLOSING:
            begin
                if (bk_closed)
                begin
                    close_nxt = 1'b0;
                    rst_t.restart = 1'b1;
                    st_nxt = RSC_CLOSED;
                end
                else if (trip_c)
                begin
                    close_nxt = 1'b0;
                    oi_t.restart = 1'b1;
                    st_nxt = last_shot ? RSC_LOCKOUT : RSC_OPEN;
                    ev[EV_LOCKOUT] = last_shot;
                end
            end
            RSC_CLOSED:
            begin
                if (trip_c || !bk_closed)
                begin
                    // next shot is taken at the next open interval expiry
                    oi_t.restart = 1'b1;
                    st_nxt = last_shot ? RSC_LOCKOUT : RSC_OPEN;
                    ev[EV_LOCKOUT] = last_shot;
                end
                else if (rst_t.expired)
                begin
                    shot_nxt = '0;
                    st_nxt = RSC_RESET;
                    ev[EV_RESET] = 1'b1;
                end
            end
            RSC_LOCKOUT:
            begin
                // lockout stands until the breaker has held closed
                if (dc_c && !bk_closed && !trip_c)
                    close_nxt = 1'b1;
                if (bk_closed || trip_c)
                    close_nxt = 1'b0;
                if (bk_rise)
                    rst_t.restart = 1'b1;
                if (rst_t.expired && bk_closed)
                begin
                    shot_nxt = '0;
                    st_nxt = RSC_RESET;
                    ev[EV_RESET] = 1'b1;
                end
            end
            default:
            begin
                st_nxt = RSC_LOCKOUT;
                close_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            st_r <= RSC_LOCKOUT;
            shot_o <= '0;
            close_o <= 1'b0;
            trip_o <= 1'b0;
            bk_q_r <= 1'b0;
            seq_pk_r <= 1'b0;
            reset_state_bit_o <= 1'b0;
            reclose_cycle_bit_o <= 1'b0;
            lockout_state_bit_o <= 1'b1;
            shot_indication_bit_o <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            shot_o <= shot_nxt;
            close_o <= close_nxt;
            trip_o <= trip_c;
            bk_q_r <= bk_closed;
            seq_pk_r <= seq_pk_nxt;
            reset_state_bit_o <= (st_nxt == RSC_RESET);
            reclose_cycle_bit_o <= (st_nxt == RSC_OPEN) || (st_nxt == RSC_CLOSING) || (st_nxt == RSC_CLOSED);
            lockout_state_bit_o <= (st_nxt == RSC_LOCKOUT);
            shot_indication_bit_o <= shot_hit(ctrl_nxt[4:0], shot_nxt);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_RS_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(reset_state_bit_o) |-> shot_o == '0)
        else $error("reset entered with nonzero shot");
    AST_SHOT_BIT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        shot_indication_bit_o == shot_hit(ctrl_r[4:0], shot_o))
        else $error("shot bit disagrees with mask");
    AST_CLOSE_INC: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(close_o) && reclose_cycle_bit_o |-> shot_o == $past(shot_o) + 1'b1)
        else $error("close without shot increment");
    AST_LO_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(lockout_state_bit_o) |-> shot_o == $past(shot_o) && !reclose_cycle_bit_o
        && shot_indication_bit_o == $past(shot_indication_bit_o))
        else $error("lockout changed the shot");
    AST_SEQ_RS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_RESET && seq_step && !trip_c |=> reset_state_bit_o ##1 !rst_t.expired)
        else $error("coordination left reset");
    AST_SEQ_MAX: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_RESET && seq_step && last_shot && !trip_c |=> $stable(shot_o))
        else $error("coordination passed last shot");
    AST_FIRST_TRIP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_RESET && trip_c && !last_shot |=> reclose_cycle_bit_o && !reset_state_bit_o)
        else $error("first trip did not start cycle");
    AST_RESET_EXP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_CLOSED && bk_closed && !trip_c && rst_t.expired
        |=> reset_state_bit_o && !reclose_cycle_bit_o && shot_o == '0)
        else $error("reset interval expiry ignored");
    AST_SEQ_CLR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_RESET && rst_t.expired && !seq_step && !trip_c |=> shot_o == '0)
        else $error("coordination count not cleared");
    AST_ONE_STATE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $onehot({reset_state_bit_o, reclose_cycle_bit_o, lockout_state_bit_o}))
        else $error("state bits not one-hot");

    COV_LOCKOUT: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        reclose_cycle_bit_o ##1 lockout_state_bit_o);
    COV_RECLOSE: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(close_o) && reclose_cycle_bit_o);
    COV_SEQ: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_r == RSC_RESET && seq_step && !last_shot);
endmodule : rsc_top

// ===== bench/rsc_breaker_model.sv
// Purpose: behavioural circuit breaker with auxiliary status contact
// Assumes: close and trip commands are levels
// Notes: closing takes three clocks of held close; trip opens next clock
`timescale 1ns/10ps
module rsc_breaker_model
(
    // clock
    input wire logic ref_clk_i,
    // commands
    input wire logic close_i,
    input wire logic trip_i,
    // auxiliary contact
    output logic closed_o
);
    logic [1:0] cnt_r = 2'h0;
    initial closed_o = 1'b0;
    // trip wins over close, as a latched-open mechanism would
    always @(posedge ref_clk_i)
    begin
        cnt_r <= close_i ? cnt_r + 2'h1 : 2'h0;
        if (trip_i)
            closed_o <= 1'b0;
        else if (cnt_r == 2'h2)
            closed_o <= 1'b1;
    end
endmodule : rsc_breaker_model

// ===== bench/reclose_shot_counter_bench.sv
// Purpose: self-checking bench of the reclose shot counter
// Assumes: short power-system cycle of four clocks
// Notes: state compares use the STATE word layout {sh,lo,cy,rs,shot}
`timescale 1ns/10ps
module reclose_shot_counter_bench;
    import rsc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic trip_pin = 1'b0;
    logic seq_pin = 1'b0;
    logic dc_pin = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic brk, close, trip, rs, cy, lo, sh, irq;
    logic [SHOT_W-1:0] shot;
    logic [7:0] exp_q [4];
    int error_cnt = 0;
    int tests_run = 0;
    rsc_top #(.CYC_CLKS(4)) rsc_top_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .breaker_closed_input_i(brk), .programmable_trip_condition_i(trip_pin),
        .seq_coord_condition_i(seq_pin), .direct_close_input_i(dc_pin), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .close_o(close), .trip_o(trip),
        .reset_state_bit_o(rs), .reclose_cycle_bit_o(cy), .lockout_state_bit_o(lo),
        .shot_indication_bit_o(sh), .shot_o(shot), .irq_o(irq));
    rsc_breaker_model rsc_breaker_model_i (.ref_clk_i(ref_clk_i), .close_i(close), .trip_i(trip),
        .closed_o(brk));
    // ----------------------------------------
    // clock, shared tasks
    // ----------------------------------------
    initial
    begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // automatic, since the watchdog counts through it at the same time
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe
    task reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    // polls under a bound, since pins pass a synchroniser of a few clocks
    task wait_st(input logic [7:0] e, input int n);
        while ({1'b0, sh, lo, cy, rs, shot} !== e && n > 0)
        begin
            @(posedge ref_clk_i);
            #1 n--;
        end
        chk("state", {24'h0, e}, {24'h0, 1'b0, sh, lo, cy, rs, shot});
    endtask : wait_st
    // pin k (0 trip, 1 coordination, 2 direct close) high for n clocks, from a rising edge
    task pulse(input int k, input int n);
        @(posedge ref_clk_i);
        {dc_pin, seq_pin, trip_pin} <= 3'(1 << k);
        tick(n);
        {dc_pin, seq_pin, trip_pin} <= 3'h0;
    endtask : pulse
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_regs;
        reg_rd(ADR_RST_IVL, rv);
        chk("rst_ivl", 32'h708, rv);
        reg_rd(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        reg_wr(ADR_CTRL, 32'h0A);
        reg_wr(ADR_RST_IVL, 32'h5);
        for (int i = 0; i < 4; i++)
            reg_wr(ADR_OI_BASE + 8'(4 * i), (i < 3) ? 32'h2 : 32'h0);
        reg_wr(ADR_IRQ_MASK, 32'h2);
        reg_rd(ADR_STATE, rv);
        chk("state_reg", 32'h20, rv);
    endtask : test_regs
    task test_close_reset;
        pulse(2, 12);
        wait_st(8'h20, 0);
        wait_st(8'h08, 80);
    endtask : test_close_reset
    task test_shots;
        pulse(0, 6);
        chk("trip", 32'h1, {31'h0, trip});
        wait_st(8'h10, 6);
        wait_st(8'h51, 60);
        chk("close", 32'h1, {31'h0, close});
        wait_st(8'h08, 80);
        exp_q = '{8'h51, 8'h12, 8'h53, 8'h63};
        foreach (exp_q[i])
        begin
            pulse(0, 6);
            wait_st(exp_q[i], 60);
            tick(6);
        end
        chk("irq", 32'h1, {31'h0, irq});
        // reset, lockout, reclose close and shot advance have all happened by now
        reg_rd(ADR_IRQ_STAT, rv);
        chk("irq_stat", 32'hF, rv);
        reg_wr(ADR_IRQ_STAT, 32'hF);
        tick(2);
        chk("irq_clr", 32'h0, {31'h0, irq});
        pulse(2, 12);
        wait_st(8'h08, 80);
    endtask : test_shots
    task test_coord;
        reg_wr(ADR_CTRL, 32'h2A);
        exp_q = '{8'h49, 8'h0A, 8'h4B, 8'h4B};
        foreach (exp_q[i])
        begin
            // the step lands a few clocks after the pin drops; look only once it has
            pulse(1, 3);
            tick(7);
            wait_st(exp_q[i], 4);
        end
        wait_st(8'h08, 60);
    endtask : test_coord
    task end_of_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        tick(16);
        rstn_i <= 1'b1;
        tick(2);
        test_regs;
        test_close_reset;
        test_shots;
        test_coord;
        end_of_test;
    end
    // the whole run needs a few hundred clocks
    initial
    begin
        tick(5000);
        error_cnt++;
        end_of_test;
    end
endmodule : reclose_shot_counter_bench
